// ---- rtl/csd_map.vh ----
// csd_map.vh: register offsets, field positions, reset values for the clock
// source select and channel divide block; included by csd_clock_divide.v
`ifndef CSD_MAP_VH
`define CSD_MAP_VH
// register offsets (indices; byte address = 4 x index)
`define CSD_IDX_CH0_COUNTS  12'h190
`define CSD_IDX_CH0_BYPASS  12'h191
`define CSD_IDX_CH0_ROUTE   12'h192
`define CSD_IDX_CH1_COUNTS  12'h196
`define CSD_IDX_CH1_BYPASS  12'h197
`define CSD_IDX_CH1_ROUTE   12'h198
`define CSD_IDX_PRESCALE    12'h1E0
`define CSD_IDX_SOURCE      12'h1E1
`define CSD_IDX_SYNC        12'h1E2
// field positions
`define CSD_BYP_BIT         7
`define CSD_SH_BIT          4
`define CSD_DIRECT_BIT      1
`define CSD_DUTYOFF_BIT     0
`define CSD_SYNC_BIT        0
// source codes
`define CSD_SRC_EXT_PRE     2'h0
`define CSD_SRC_EXT_DIRECT  2'h1
`define CSD_SRC_OSC_PRE     2'h2
`define CSD_SRC_BAD         2'h3
// reset values
`define CSD_RST_COUNTS      8'h00
`define CSD_RST_BYPASS      8'h00
`define CSD_RST_ROUTE       8'h00
`define CSD_RST_PRESCALE    8'h00
`define CSD_RST_SOURCE      8'h00
`endif

// ---- rtl/csd_clock_divide.v ----
// csd_clock_divide.v: source select, prescaler and two channel dividers with
// an APB register slave. assumes all inputs synchronous to clk, and that the
// source clocks arrive as sampled level inputs (enable-style model).
//
// Decided for this implementation: the APB register port.
`timescale 1ns/10ps
`include "csd_map.vh"
module csd_clock_divide
(
  // clock, reset, enable
  input  wire        clk,
  input  wire        rst,
  input  wire        clkEn,
  // clock sources, sampled levels
  input  wire        extClk,
  input  wire        oscClk,
  // apb slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [13:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  // outputs
  output reg         pair0_output_a,
  output reg         pair0_output_b,
  output reg         pair1_output_a,
  output reg         pair1_output_b,
  output reg  [1:0]  dividerPowered
);
  // register file
  reg  [7:0]  cntQ [0:1];   // low/high counts per channel
  reg  [7:0]  bypQ [0:1];   // bypass, start high, phase offset
  reg  [7:0]  rteQ [0:1];   // direct route, duty_fix_off
  reg  [7:0]  preQ;         // prescaler ratio field
  reg  [7:0]  srcQ;         // source select
  reg  [11:0] idx;          // word index
  reg         hit;          // mapped index
  reg  [7:0]  rdVal;        // read mux
  reg         syncReq;      // one-cycle sync request
  wire        acc = psel & penable;
  wire        wrAcc = acc & pwrite & hit;

  // address decode shared by reads and writes
  function [4:0] decode;
    input [11:0] i;
    begin
      case (i)
        `CSD_IDX_CH0_COUNTS: decode = 5'h10;
        `CSD_IDX_CH0_BYPASS: decode = 5'h11;
        `CSD_IDX_CH0_ROUTE:  decode = 5'h12;
        `CSD_IDX_CH1_COUNTS: decode = 5'h14;
        `CSD_IDX_CH1_BYPASS: decode = 5'h15;
        `CSD_IDX_CH1_ROUTE:  decode = 5'h16;
        `CSD_IDX_PRESCALE:   decode = 5'h18;
        `CSD_IDX_SOURCE:     decode = 5'h19;
        `CSD_IDX_SYNC:       decode = 5'h1A;
        default:             decode = 5'h00;
      endcase
    end
  endfunction

  // read mux
  always @*
  begin
    idx = paddr[13:2];
    hit = decode(idx) != 5'h00 && paddr[1:0] == 2'h0;
    case (decode(idx))
      5'h10:   rdVal = cntQ[0];
      5'h11:   rdVal = bypQ[0];
      5'h12:   rdVal = rteQ[0];
      5'h14:   rdVal = cntQ[1];
      5'h15:   rdVal = bypQ[1];
      5'h16:   rdVal = rteQ[1];
      5'h18:   rdVal = preQ;
      5'h19:   rdVal = srcQ;
      default: rdVal = 8'h00;   // sync reads zero
    endcase
  end

  // apb slave: no wait states, ready in first access cycle
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      prdata  <= 32'h00000000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
      cntQ[0] <= `CSD_RST_COUNTS;
      cntQ[1] <= `CSD_RST_COUNTS;
      bypQ[0] <= `CSD_RST_BYPASS;
      bypQ[1] <= `CSD_RST_BYPASS;
      rteQ[0] <= `CSD_RST_ROUTE;   // duty correction on
      rteQ[1] <= `CSD_RST_ROUTE;
      preQ    <= `CSD_RST_PRESCALE;
      srcQ    <= `CSD_RST_SOURCE;
      syncReq <= 1'b0;
    end
    else if (clkEn)
    begin
      pready  <= psel & ~penable;
      pslverr <= psel & ~penable & ~hit;
      prdata  <= (psel & ~penable & ~pwrite) ? {24'h000000, rdVal} : 32'h00000000;
      syncReq <= 1'b0;
      if (wrAcc & pready)
      begin
        case (decode(idx))
          5'h10:   cntQ[0] <= pwdata[7:0];
          5'h11:   bypQ[0] <= pwdata[7:0];
          5'h12:   rteQ[0] <= pwdata[7:0];
          5'h14:   cntQ[1] <= pwdata[7:0];
          5'h15:   bypQ[1] <= pwdata[7:0];
          5'h16:   rteQ[1] <= pwdata[7:0];
          5'h18:   preQ    <= pwdata[7:0];
          5'h19:   srcQ    <= pwdata[7:0];
          5'h1A:   syncReq <= pwdata[`CSD_SYNC_BIT];
          default: syncReq <= 1'b0;
        endcase
      end
    end
  end

  // source selection and edge detect of the selected clock
  reg  srcLvl;      // selected raw source level
  reg  srcPrevQ;    // previous source level
  wire srcBad  = srcQ[1:0] == `CSD_SRC_BAD;
  wire usePre  = srcQ[1:0] != `CSD_SRC_EXT_DIRECT;
  always @*
  begin
    srcLvl = (srcQ[1:0] == `CSD_SRC_OSC_PRE) ? oscClk : extClk;
  end
  wire srcRise = srcLvl & ~srcPrevQ;

  // prescaler: ratio 2..6 from 3-bit field, clamped
  reg [2:0] preCntQ;
  reg       preOutQ;
  reg [2:0] preRatio;
  always @*
  begin
    case (preQ[2:0])
      3'h0:    preRatio = 3'h2;
      3'h1:    preRatio = 3'h3;
      3'h2:    preRatio = 3'h4;
      3'h3:    preRatio = 3'h5;
      default: preRatio = 3'h6;
    endcase
  end
  wire preTick = srcRise && preCntQ == 3'h0;   // one tick per ratio edges
  wire divTick = usePre ? preTick : srcRise;   // divider input edge

  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      srcPrevQ <= 1'b0;
      preCntQ  <= 3'h0;
      preOutQ  <= 1'b0;
    end
    else if (clkEn)
    begin
      srcPrevQ <= srcLvl;
      if (srcRise)
      begin
        preCntQ <= (preCntQ == preRatio - 3'h1) ? 3'h0 : preCntQ + 3'h1;
        // high for (ratio >> 1) + 1 of the ratio source edges of each prescaler period
        preOutQ <= (preCntQ < (preRatio >> 1)) | (preCntQ == preRatio - 3'h1);
      end
    end
  end
  wire divIn = usePre ? preOutQ : srcLvl;   // level fed to bypassed divider

  // two first-type channel dividers
  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1)
    begin : chan
      reg  [4:0] cntQ2;    // position within period
      reg        outQ;     // divided output
      reg        halfQ;    // copy delayed one clk cycle for correction
      reg  [4:0] dlyQ;     // delay cycles still pending
      reg  [4:0] phiQ;     // active delay, latched at sync
      wire [3:0] lowM  = cntQ[g][7:4];   // low count minus one
      wire [3:0] highN = cntQ[g][3:0];   // high count minus one
      wire [4:0] hiLen = {1'b0, highN} + 5'h01;
      wire [4:0] total = {1'b0, highN} + {1'b0, lowM} + 5'h02;
      wire       byp   = bypQ[g][`CSD_BYP_BIT];
      wire [4:0] phi   = bypQ[g][4:0];
      wire [4:0] dly   = phi[4] ? phi - 5'h10 + {1'b0, lowM} + 5'h01 : phi;
      wire       dutyOn = ~rteQ[g][`CSD_DUTYOFF_BIT];
      wire       odd   = total[0];
      always @(posedge clk or posedge rst)
      begin
        if (rst)
        begin
          cntQ2 <= 5'h00;
          outQ  <= 1'b0;
          halfQ <= 1'b0;
          dlyQ  <= 5'h00;
          phiQ  <= 5'h00;
        end
        else if (clkEn)
        begin
          if (syncReq | srcBad)
          begin
            // restart static, load new delay
            cntQ2 <= 5'h00;
            outQ  <= 1'b0;
            halfQ <= 1'b0;
            phiQ  <= dly;
            dlyQ  <= dly;
          end
          else if (~byp && divTick)
          begin
            if (dlyQ != 5'h00)
              dlyQ <= dlyQ - 5'h01;
            else
            begin
              cntQ2 <= (cntQ2 == total - 5'h01) ? 5'h00 : cntQ2 + 5'h01;
              outQ  <= (cntQ2 == total - 5'h01) | (cntQ2 < hiLen - 5'h01);
            end
          end
          else if (~byp)
            halfQ <= outQ;             // delayed copy for odd correction
        end
      end
      // correction widens odd high phase by one clk cycle
      wire divOut = (dutyOn & odd) ? (outQ | halfQ) : outQ;
      // bypass passes input; divider state idles (powered down)
      wire chOut  = srcBad ? 1'b0 : (rteQ[g][`CSD_DIRECT_BIT] ? srcLvl : (byp ? divIn : divOut));
      if (g == 0)
      begin : p0
        always @(posedge clk or posedge rst)
        begin
          if (rst)
          begin
            pair0_output_a <= 1'b0;
            pair0_output_b <= 1'b0;
          end
          else if (clkEn)
          begin
            pair0_output_a <= chOut;
            pair0_output_b <= chOut;
          end
        end
      end
      else
      begin : p1
        always @(posedge clk or posedge rst)
        begin
          if (rst)
          begin
            pair1_output_a <= 1'b0;
            pair1_output_b <= 1'b0;
          end
          else if (clkEn)
          begin
            pair1_output_a <= chOut;
            pair1_output_b <= chOut;
          end
        end
      end
    end
  endgenerate

  // power flag per channel, one process so the vector has a single driver
  always @(posedge clk or posedge rst)
  begin
    if (rst)
      dividerPowered <= 2'h0;
    else if (clkEn)
      dividerPowered <= {~bypQ[1][`CSD_BYP_BIT], ~bypQ[0][`CSD_BYP_BIT]};
  end
endmodule // csd_clock_divide

// ---- tb/csd_clock_divide_assertions.sv ----
// csd_clock_divide_assertions.sv: port checker for the divide block
// assumes: bound onto csd_clock_divide, one clock domain
`timescale 1ns/10ps
module csd_chk (
  // clock, reset, enable
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        clkEn,
  // apb
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [31:0] prdata,
  // outputs
  input wire logic        pair0_output_a,
  input wire logic        pair0_output_b,
  input wire logic        pair1_output_a,
  input wire logic        pair1_output_b
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // ready follows setup by one cycle
  chk_apb_answer: assert property (psel && !penable && clkEn |=> pready)
    else $error("ready missing after setup");
  chk_ready_access: assert property (pready |-> psel && penable)
    else $error("ready outside access");
  chk_ready_pulse: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  chk_err_ready: assert property (pslverr |-> pready)
    else $error("error without ready");
  chk_upper_zero: assert property (pready |-> prdata[31:8] == 24'h0)
    else $error("read data upper bits set");
  chk_pair0_same: assert property (pair0_output_a == pair0_output_b)
    else $error("pair0 outputs differ");
  chk_pair1_same: assert property (pair1_output_a == pair1_output_b)
    else $error("pair1 outputs differ");
  chk_freeze_hold: assert property (!clkEn |=> $stable(pair0_output_a) && $stable(pair1_output_a))
    else $error("outputs moved while frozen");
  chk_reset_quiet: assert property ($fell(rst) |-> !pair0_output_a && !pair1_output_a)
    else $error("outputs high after reset");
  // main scenarios
  cover property ($rose(pair0_output_a));
  cover property ($rose(pair1_output_a));
  cover property (pslverr);
endmodule // csd_chk

bind csd_clock_divide csd_chk chk_u (.clk(clk), .rst(rst), .clkEn(clkEn), .psel(psel),
  .penable(penable), .pready(pready), .pslverr(pslverr), .prdata(prdata),
  .pair0_output_a(pair0_output_a), .pair0_output_b(pair0_output_b),
  .pair1_output_a(pair1_output_a), .pair1_output_b(pair1_output_b));

// ---- tb/csd_load.sv ----
// csd_load.sv: clocked load, measures period and high time of one output
// assumes: output sampled on clk, counts in clk cycles
`timescale 1ns/10ps
module csd_load (
  // sampling clock and watched output
  input wire logic clk,
  input wire logic outLevel,
  // last full period and its high time
  output int       period,
  output int       hiLen
);
  int   cnt;  // cycles since last rise
  int   hiCnt; // high cycles since last rise
  logic prev; // previous level
  // restart counts at each rising edge
  always @(posedge clk)
  begin
    prev <= outLevel;
    cnt <= cnt + 1;
    if (outLevel)
      hiCnt <= hiCnt + 1;
    if (outLevel && !prev)
    begin
      period <= cnt;
      hiLen <= hiCnt;
      cnt <= 1;
      hiCnt <= 1;
    end
  end
endmodule // csd_load

// ---- tb/test_csd_clock_divide.sv ----
// test_csd_clock_divide.sv: self-checking bench for the divide block
// assumes: ext source toggles each clk, oscillator every two clk
`timescale 1ns/10ps
module test_csd_clock_divide;
  logic        clk = 0, rst = 1, clkEn = 1, extClk = 0, oscClk = 0;
  logic        psel = 0, penable = 0, pwrite = 0, pready, pslverr, er;
  logic [13:0] paddr = 14'h0;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic        p0a, p0b, p1a, p1b;
  logic [1:0]  dividerPowered;
  int          error_cnt = 0, total_checks = 0, per0, hi0, per1, hi1;
  typedef struct {logic [1:0] src; logic [2:0] pre; logic [7:0] cnt; logic off; int per; int hi;} csd_row_t;
  // source, prescale, counts, duty off, period, high (0 skips)
  csd_row_t rows[6] = '{'{2'h1, 3'h0, 8'h10, 1'h1, 6, 2}, '{2'h1, 3'h0, 8'h33, 1'h1, 16, 8},
    '{2'h0, 3'h0, 8'h10, 1'h0, 12, 0}, '{2'h0, 3'h4, 8'h00, 1'h0, 24, 0},
    '{2'h2, 3'h1, 8'h00, 1'h0, 24, 0}, '{2'h0, 3'h2, 8'hFF, 1'h0, 256, 0}};
  logic [11:0] regIdx[8] = '{12'h190, 12'h191, 12'h192, 12'h196, 12'h197, 12'h198, 12'h1E0, 12'h1E1};
  initial forever #5 clk = ~clk;
  // source levels
  always @(posedge clk)
  begin
    extClk <= ~extClk;
    if (extClk)
      oscClk <= ~oscClk;
  end
  csd_clock_divide dut_u (.clk(clk), .rst(rst), .clkEn(clkEn), .extClk(extClk), .oscClk(oscClk),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .pair0_output_a(p0a), .pair0_output_b(p0b),
    .pair1_output_a(p1a), .pair1_output_b(p1b), .dividerPowered(dividerPowered));
  csd_load load0_u (.clk(clk), .outLevel(p0a), .period(per0), .hiLen(hi0));
  csd_load load1_u (.clk(clk), .outLevel(p1a), .period(per1), .hiLen(hi1));
  task chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // one apb transfer, byte address is four times the index
  task apb(input logic w, input logic [11:0] idx, input logic [7:0] wd);
    int n;
    psel <= 1;
    pwrite <= w;
    paddr <= {idx, 2'h0};
    pwdata <= {24'h0, wd};
    @(posedge clk);
    penable <= 1;
    n = 0;
    do begin @(posedge clk); n++; end while (pready !== 1'b1 && n < 50);
    if (n >= 50)
      error_cnt++;
    rd = prdata;
    er = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge clk);
  endtask
  task cfg(input logic [11:0] b, input logic [7:0] cnt, input logic [7:0] byp, input logic [7:0] rt);
    apb(1, b, cnt);
    apb(1, b + 12'h1, byp);
    apb(1, b + 12'h2, rt);
  endtask
  task settle(input int p);
    repeat (3 * p + 40) @(posedge clk);
  endtask
  task tally_and_finish;
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // hang guard, about thirty times the expected run
  initial
  begin
    #500000;
    error_cnt++;
    tally_and_finish;
  end
  initial
  begin
    repeat (16) @(posedge clk);
    rst <= 0;
    @(posedge clk);
    foreach (regIdx[i])
    begin
      apb(0, regIdx[i], 8'h00);
      chk(rd, 32'h0);
    end
    apb(0, 12'h193, 8'h00);
    chk(er, 1'b1);
    chk(rd, 32'h0);
    $display("register test done");
    foreach (rows[i])
    begin
      cfg(12'h190, rows[i].cnt, 8'h00, {7'h0, rows[i].off});
      cfg(12'h196, rows[i].cnt, 8'h00, {7'h0, rows[i].off});
      apb(1, 12'h1E0, {5'h0, rows[i].pre});
      apb(1, 12'h1E1, {6'h0, rows[i].src});
      apb(1, 12'h1E2, 8'h01);
      settle(rows[i].per);
      chk(per0, rows[i].per);
      chk(per1, rows[i].per);
      if (rows[i].hi != 0)
        chk(hi0, rows[i].hi);
      $display("row %0d done", i);
    end
    cfg(12'h190, 8'h10, 8'h80, 8'h00);
    apb(1, 12'h1E1, 8'h01);
    apb(1, 12'h1E2, 8'h01);
    settle(4);
    chk(dividerPowered, 2'h2);
    chk(per0, 2);
    apb(0, 12'h190, 8'h00);
    chk(rd, 32'h10);
    chk(er, 1'b0);
    $display("bypass test done");
    apb(1, 12'h1E1, 8'h00);
    cfg(12'h196, 8'hFF, 8'h00, 8'h02);
    settle(4);
    chk(per1, 2);
    clkEn <= 0;
    repeat (3) @(posedge clk);
    clkEn <= 1;
    $display("direct test done");
    apb(1, 12'h198, 8'h00);
    apb(1, 12'h1E1, 8'h03);
    repeat (20) @(posedge clk);
    repeat (8)
    begin
      @(posedge clk);
      chk(p0a, 1'b0);
      chk(p1a, 1'b0);
    end
    $display("bad source test done");
    tally_and_finish;
  end
endmodule // test_csd_clock_divide
